// file: nis_pkg.sv
// Package: offsets, layouts and reset values of the event status block
package nis_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int         ADDR_W           = 4;
    localparam logic [3:0] CMD_ADDR         = 4'h0; // Command register
    localparam logic [3:0] EVENT_STATUS_ADDR = 4'h7; // Event status
    localparam logic [3:0] EVENT_MASK_ADDR  = 4'hF; // Event mask

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int         NUM_EVENTS      = 7;
    localparam int         RST_STATE_BIT   = 7;
    localparam int         CMD_STOP_BIT    = 0;
    localparam int         CMD_START_BIT   = 1;
    localparam logic [6:0] FLAGS_RESET     = 7'h00;
    localparam logic [6:0] MASK_RESET      = 7'h00;
    localparam logic       RST_STATE_RESET = 1'b1;
    localparam logic [7:0] RDATA_RESET     = 8'h00;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // Event strobes, one bit per status position 6..0
    typedef struct packed {
        logic remote_dma_done_flag;
        logic tally_overflow_flag;
        logic ring_exhausted_flag;
        logic tx_error_flag;
        logic rx_error_flag;
        logic tx_ok_flag;
        logic rx_ok_flag;
    } nis_events_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } nis_bus_req_t;

    // Top level state
    typedef struct packed {
        logic [7:0] rdata;
        logic [6:0] mask;
        logic       rst_state;
        logic       running;
        logic       irq;
    } nis_regs_t;

    // Sticky flag cell state
    typedef struct packed {
        logic flag;
    } nis_cell_t;

endpackage

// file: nis_flag_cell.sv
// Sticky event flag: set by a strobe, cleared by a write of one
`timescale 1ns/1ps
`default_nettype none
module nis_flag_cell #(
    parameter logic RESET_VAL = 1'b0  // Value after reset
) (
    input  wire logic mclk,   // System clock
    input  wire logic rst,    // Synchronous reset
    input  wire logic set,    // Event strobe
    input  wire logic clr,    // Write-one clear
    output var  logic flag_d, // Next value
    output var  logic flag_q  // Registered flag
);
    import nis_pkg::*;

    nis_cell_t s_q;
    nis_cell_t s_d;

    // Set beats clear so a coincident event survives
    always_comb begin
        s_d      = s_q;
        s_d.flag = set | (s_q.flag & ~clr);
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q.flag <= RESET_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    assign flag_d = s_d.flag;
    assign flag_q = s_q.flag;

endmodule
`default_nettype wire

// file: nis_top.sv
// Event status, mask and interrupt output of the network controller
//
// Contract
// - Event status at offset 07H, read/write.
// - Writing one clears flag; zero leaves it.
// - Interrupt high while any unmasked flag set.
// - Bit 0 set on error-free receive.
// - Bit 1 set on error-free transmit.
// - Bit 2 set on any receive error.
// - Bit 3 set on collisions or underrun.
// - Bit 4 set when receive ring exhausted.
// - Bit 5 set on tally counter MSB.
// - Bit 6 set on remote DMA completion.
// - Bit 7 set at reset, cleared by start.
// - Bit 7 set on overflow, cleared on removal.
// - Status writes never change bit 7.
// - Bit 7 never drives the interrupt.
// - Mask bits 6..0 enable flags; 7 reserved.
`timescale 1ns/1ps
`default_nettype none
module nis_top (
    input  wire logic                  mclk,          // 100 MHz clock
    input  wire logic                  rst,           // Sync reset, high
    input  wire nis_pkg::nis_bus_req_t bus,           // Register request
    input  wire nis_pkg::nis_events_t  events,        // Event strobes
    input  wire logic                  ring_overflow, // Ring overflowed
    input  wire logic                  ring_released, // Packet removed
    output var  logic [7:0]            rdata,         // Read data
    output var  logic                  irq,           // Interrupt, high
    output var  logic                  stopped        // Bit 7 state
);
    import nis_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    nis_regs_t  r_q;
    nis_regs_t  r_d;
    logic [6:0] flags_q;
    logic [6:0] flags_d;
    logic [6:0] ev_vec;
    logic [6:0] clr_vec;
    logic       wr_status;
    logic       wr_mask;
    logic       wr_cmd;
    logic       start_cmd;
    logic       stop_cmd;
    logic       bit7_set;
    logic       bit7_clr;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Strobes are one cycle, so a decode hit is a single action
    assign wr_status = bus.wr && (bus.addr == EVENT_STATUS_ADDR);
    assign wr_mask   = bus.wr && (bus.addr == EVENT_MASK_ADDR);
    assign wr_cmd    = bus.wr && (bus.addr == CMD_ADDR);
    assign stop_cmd  = wr_cmd && bus.wdata[CMD_STOP_BIT];
    // Stop beats start when both bits arrive together
    assign start_cmd = wr_cmd && bus.wdata[CMD_START_BIT] && !stop_cmd;

    // ****************************************************************
    // Event flags 6..0
    // ****************************************************************
    // Packed order of the carrier matches status bit order
    assign ev_vec  = events;
    // Only bits 6..0 take a write-one clear
    assign clr_vec = wr_status ? bus.wdata[6:0] : 7'h00;

    // One sticky cell per flag; set wins inside the cell
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_flag
            nis_flag_cell #(
                .RESET_VAL (FLAGS_RESET[gi])
            ) u_cell (
                .mclk   (mclk),
                .rst    (rst),
                .set    (ev_vec[gi]),
                .clr    (clr_vec[gi]),
                .flag_d (flags_d[gi]),
                .flag_q (flags_q[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Reset-state bit 7 conditions
    // ****************************************************************
    // Host writes to the status word never reach bit 7
    assign bit7_set = stop_cmd | ring_overflow;
    assign bit7_clr = start_cmd | ring_released;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        r_d = r_q;
        // Bit 7: set beats clear, as for the other flags
        if (bit7_set) begin
            r_d.rst_state = 1'b1;
        end else if (bit7_clr) begin
            r_d.rst_state = 1'b0;
        end
        // Controller run state follows commands only
        if (stop_cmd) begin
            r_d.running = 1'b0;
        end else if (start_cmd) begin
            r_d.running = 1'b1;
        end
        // Mask holds bits 6..0; bit 7 is not stored
        if (wr_mask) begin
            r_d.mask = bus.wdata[6:0];
        end
        // Interrupt from next values so it tracks the flags exactly;
        // bit 7 is left out on purpose
        r_d.irq = |(flags_d & r_d.mask);
        // Read data valid one cycle after the strobe only
        r_d.rdata = RDATA_RESET;
        if (bus.rd) begin
            case (bus.addr)
                EVENT_STATUS_ADDR: begin
                    r_d.rdata = {r_q.rst_state, flags_q};
                end
                EVENT_MASK_ADDR: begin
                    r_d.rdata = {1'b0, r_q.mask};
                end
                CMD_ADDR: begin
                    r_d.rdata = {6'h00, r_q.running, ~r_q.running};
                end
                default: begin
                    r_d.rdata = RDATA_RESET;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Bit 7 comes up set: the controller starts in reset state
    always_ff @(posedge mclk) begin
        if (rst) begin
            r_q.rdata     <= RDATA_RESET;
            r_q.mask      <= MASK_RESET;
            r_q.rst_state <= RST_STATE_RESET;
            r_q.running   <= 1'b0;
            r_q.irq       <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata   = r_q.rdata;
    assign irq     = r_q.irq;
    assign stopped = r_q.rst_state;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Clear of bit 0 without a coincident event empties it
    AST_CLEAR_ONE: assert property (
        (wr_status && bus.wdata[0] && !events.rx_ok_flag)
        |=> !flags_q[0])
        else $error("write of one did not clear flag 0");

    // Zero written to a set flag keeps it
    AST_ZERO_KEEPS: assert property (
        (wr_status && !bus.wdata[3] && flags_q[3])
        |=> flags_q[3])
        else $error("write of zero changed flag 3");

    // Event and clear in one cycle: the flag ends set
    AST_SET_WINS: assert property (
        (wr_status && bus.wdata[6] && events.remote_dma_done_flag)
        |=> flags_q[6])
        else $error("coincident event lost on flag 6");

    // Every strobe shows in its own bit next cycle
    AST_EVENT_SETS: assert property (
        (ev_vec != 7'h00)
        |=> ((flags_q & $past(ev_vec)) == $past(ev_vec)))
        else $error("event strobe did not set its flag");

    // Interrupt stays high until unmasked flags are gone
    AST_IRQ_LEVEL: assert property (
        (irq && (|(flags_q & r_q.mask)))
        |-> ##1 (irq || !(|($past(flags_q) & $past(r_q.mask))) ||
                 !(|(flags_q & r_q.mask))))
        else $error("interrupt fell with an unmasked flag set");

    // Interrupt equals the unmasked OR of flags 6..0
    AST_IRQ_MATCH: assert property (
        irq == (|(flags_q & r_q.mask)))
        else $error("interrupt does not match unmasked flags");

    // Bit 7 alone never raises the interrupt
    AST_BIT7_QUIET: assert property (
        (r_q.rst_state && ((flags_q & r_q.mask) == 7'h00))
        |-> !irq)
        else $error("reset-state bit raised the interrupt");

    // Status writes leave bit 7 untouched
    AST_BIT7_WRITE: assert property (
        (wr_status && !ring_overflow && !ring_released)
        |=> $stable(r_q.rst_state))
        else $error("host write changed bit 7");

    // Start command clears bit 7 when no overflow coincides
    AST_START_CLEARS: assert property (
        (start_cmd && !ring_overflow)
        |=> !r_q.rst_state)
        else $error("start did not clear bit 7");

    // Overflow sets bit 7 even against a release
    AST_OVERFLOW_SETS: assert property (
        ring_overflow |=> (r_q.rst_state && stopped))
        else $error("ring overflow did not set bit 7");

    // Release without other causes clears bit 7
    AST_RELEASE_CLEARS: assert property (
        (ring_released && !ring_overflow && !stop_cmd)
        |=> !r_q.rst_state)
        else $error("packet removal did not clear bit 7");

    // Status read returns the word seen at the strobe
    AST_STATUS_READ: assert property (
        (bus.rd && (bus.addr == EVENT_STATUS_ADDR))
        |=> (rdata == {$past(r_q.rst_state), $past(flags_q)}))
        else $error("status read returned wrong data");

    // Mask bit 7 always reads as zero
    AST_MASK_RSVD: assert property (
        (bus.rd && (bus.addr == EVENT_MASK_ADDR))
        |=> (rdata[7] == 1'b0) && (rdata[6:0] == $past(r_q.mask)))
        else $error("mask read wrong or reserved bit set");

    // Read data only in the cycle after a read strobe
    AST_RDATA_IDLE: assert property (
        !bus.rd |=> (rdata == 8'h00))
        else $error("read data present without a read");

    // ****************************************************************
    // Per-flag, mask and command checks
    // ****************************************************************
    // Receive-ok strobe sets bit 0
    AST_RX_OK_SETS: assert property (
        events.rx_ok_flag |=> flags_q[0])
        else $error("receive-ok event did not set flag 0");

    // Transmit-ok strobe sets bit 1
    AST_TX_OK_SETS: assert property (
        events.tx_ok_flag |=> flags_q[1])
        else $error("transmit-ok event did not set flag 1");

    // Receive error strobe sets bit 2
    AST_RX_ERR_SETS: assert property (
        events.rx_error_flag |=> flags_q[2])
        else $error("receive error event did not set flag 2");

    // Transmit error strobe sets bit 3
    AST_TX_ERR_SETS: assert property (
        events.tx_error_flag |=> flags_q[3])
        else $error("transmit error event did not set flag 3");

    // Ring exhaustion strobe sets bit 4
    AST_RING_SETS: assert property (
        events.ring_exhausted_flag |=> flags_q[4])
        else $error("ring exhaustion did not set flag 4");

    // Tally overflow strobe sets bit 5
    AST_TALLY_SETS: assert property (
        events.tally_overflow_flag |=> flags_q[5])
        else $error("tally overflow did not set flag 5");

    // Remote transfer done strobe sets bit 6
    AST_DMA_SETS: assert property (
        events.remote_dma_done_flag |=> flags_q[6])
        else $error("remote transfer done did not set flag 6");

    // No status write, so no flag may fall
    AST_FLAG_HOLD: assert property (
        !wr_status |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("flag fell without a status write");

    // No strobe, so no flag may rise
    AST_NO_SPURIOUS: assert property (
        (ev_vec == 7'h00) |=> ((flags_q & ~$past(flags_q)) == 7'h00))
        else $error("flag rose without an event strobe");

    // Stop command puts bit 7 up
    AST_STOP_SETS: assert property (
        stop_cmd |=> r_q.rst_state)
        else $error("stop command did not set bit 7");

    // Bit 7 moves only on its own causes
    AST_BIT7_HOLD: assert property (
        (!bit7_set && !bit7_clr) |=> $stable(r_q.rst_state))
        else $error("bit 7 changed without a cause");

    // Set and clear of bit 7 together: set wins
    AST_BIT7_SET_WINS: assert property (
        (bit7_set && bit7_clr) |=> r_q.rst_state)
        else $error("bit 7 set lost to a coincident clear");

    // Mask write lands with bits 6..0 only
    AST_MASK_WRITE: assert property (
        wr_mask |=> (r_q.mask == $past(bus.wdata[6:0])))
        else $error("mask write did not land");

    // Empty mask keeps the interrupt low
    AST_MASK_GATES: assert property (
        (r_q.mask == 7'h00) |-> !irq)
        else $error("interrupt high with an empty mask");

    // No unmasked flag, no interrupt
    AST_IRQ_LOW: assert property (
        ((flags_q & r_q.mask) == 7'h00) |-> !irq)
        else $error("interrupt high with no unmasked flag");

    // Command read returns the run state pair
    AST_CMD_READ: assert property (
        (bus.rd && (bus.addr == CMD_ADDR))
        |=> (rdata == {6'h00, $past(r_q.running), ~$past(r_q.running)}))
        else $error("command read returned wrong data");

    // Unmapped reads return zero
    AST_UNMAPPED_READ: assert property (
        (bus.rd && (bus.addr != CMD_ADDR) &&
         (bus.addr != EVENT_STATUS_ADDR) &&
         (bus.addr != EVENT_MASK_ADDR))
        |=> (rdata == 8'h00))
        else $error("unmapped read returned data");

endmodule
`default_nettype wire

// file: nis_host_model.sv
// Host processor model driving the register port of the status block
`timescale 1ns/1ps
`default_nettype none
module nis_host_model (
    output var nis_pkg::nis_bus_req_t bus // Register request
);
    import nis_pkg::*;

    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Idle port from time zero, so no strobe is seen before reset ends
    initial begin
        bus = '0;
    end

    // One bus cycle; called just past a rising edge, held until the next call
    task automatic op(input logic w, input logic r,
                      input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask

    // Power-up clear: ones to every status position
    task automatic clear_all();
        op(1'b1, 1'b0, EVENT_STATUS_ADDR, 8'hFF);
    endtask
endmodule
`default_nettype wire

// file: nic_interrupt_status_tb.sv
// Self-checking bench for the event status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module nic_interrupt_status_tb;
    import nis_pkg::*;

    // ****************************************************************
    // Design, host and signals
    // ****************************************************************
    logic         mclk          = 1'b0;
    logic         rst           = 1'b1;
    nis_bus_req_t bus;
    nis_events_t  events        = '0;
    logic         ring_overflow = 1'b0;
    logic         ring_released = 1'b0;
    logic [7:0]   rdata;
    logic         irq;
    logic         stopped;
    int           num_errors    = 0;
    int           n_tests       = 0;
    int           seed          = 2;
    int           go            = 0;
    int           fl, mk, b7, run, erd, st, sa;
    logic [3:0]   pick [4] = '{CMD_ADDR, EVENT_STATUS_ADDR,
                               EVENT_MASK_ADDR, 4'h3};

    nis_top i_nis_top (
        .mclk(mclk), .rst(rst), .bus(bus), .events(events),
        .ring_overflow(ring_overflow), .ring_released(ring_released),
        .rdata(rdata), .irq(irq), .stopped(stopped));

    nis_host_model i_nis_host_model (.bus(bus));

    // 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    // ****************************************************************
    // Reference model, stepped on the same edges as the design
    // ****************************************************************
    // Inputs are read before this edge's updates land
    always @(posedge mclk) begin
        if (rst) begin
            fl = 0;
            mk = 0;
            b7 = 1;
            run = 0;
            erd = 0;
        end else begin
            erd = 0;
            if (bus.rd && bus.addr == EVENT_STATUS_ADDR) erd = b7 * 128 + fl;
            if (bus.rd && bus.addr == EVENT_MASK_ADDR) erd = mk;
            if (bus.rd && bus.addr == CMD_ADDR) erd = run * 2 + 1 - run;
            if (bus.wr && bus.addr == EVENT_STATUS_ADDR)
                fl = fl & ~bus.wdata[6:0];
            if (bus.wr && bus.addr == EVENT_MASK_ADDR) mk = bus.wdata[6:0];
            st = bus.wr && bus.addr == CMD_ADDR && bus.wdata[0];
            sa = bus.wr && bus.addr == CMD_ADDR && !bus.wdata[0]
                 && bus.wdata[1];
            if (st) run = 0;
            if (sa) run = 1;
            // Set beats clear, so no event is lost
            if (st || ring_overflow) b7 = 1;
            else if (sa || ring_released) b7 = 0;
            fl = fl | events;
        end
    end

    // Compare every settled cycle, mid-cycle away from the edges
    always @(negedge mclk) begin
        if (go) begin
            check("rdata", rdata, erd[7:0]);
            check("irq", irq, 8'((fl & mk) != 0));
            check("stopped", stopped, b7[7:0]);
        end
    end

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ****************************************************************
    // Stimulus and verdict
    // ****************************************************************
    // Random events and host cycles; em enables events per flag
    task automatic burst(input int n, input logic [6:0] em);
        int         k;
        logic [3:0] a;
        repeat (n) begin
            @(posedge mclk);
            k = $random(seed) & 7;
            a = pick[$random(seed) & 3];
            events <= 7'(em & $random(seed) & $random(seed)
                         & $random(seed));
            ring_overflow <= ($random(seed) & 63) == 0;
            ring_released <= ($random(seed) & 63) == 0;
            i_nis_host_model.op(k < 2, k == 2 || k == 3, a,
                                8'($random(seed)));
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Reset, power-up clear, busy phase, quiet drain, reset mid-run
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        go = 1;
        @(posedge mclk);
        i_nis_host_model.clear_all();
        burst(1500, 7'h7F);
        burst(300, 7'h00);
        @(posedge mclk);
        rst <= 1'b1;
        i_nis_host_model.op(1'b0, 1'b0, 4'h0, 8'h00);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        i_nis_host_model.clear_all();
        burst(1000, 7'h7F);
        @(posedge mclk);
        give_verdict();
    end

    // Run needs about 2820 cycles; a hang is cut off well beyond that
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
